// *** hdl/aah_core.sv ***
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "aah_consts.svh"
module aah_core #(
    parameter int DEPTH = 4,
    parameter int NCFG = 4,
    parameter int RESEND_CYC = `AAH_RESEND_CYC,
    parameter int MRSP_CYC = `AAH_MRSP_CYC
) (
    input wire logic mclk, // System clock
    input wire logic rst, // Async reset
    input wire logic [7:0] wb_adr_i, // Byte address
    input wire logic [31:0] wb_dat_i, // Write data
    output logic [31:0] wb_dat_o, // Read data
    input wire logic wb_we_i, // Write enable
    input wire logic [3:0] wb_sel_i, // Byte lanes
    input wire logic wb_cyc_i, // Cycle
    input wire logic wb_stb_i, // Strobe
    output logic wb_ack_o, // Ack
    input wire logic [1:0] port_oper_raw, // New link seen per port (pin)
    input wire logic [1:0] addr_err_raw, // Frame to non-operational port (pin)
    output logic [1:0] port_oper_flag, // Operational flags
    output logic [NCFG-1:0] cfg_reset // Reset a silent configuring node
);
    localparam int QW = $clog2(DEPTH);
    localparam int CW = $clog2(NCFG);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [31:0] ctrl_r;
    logic [31:0] rxmsg_r;
    logic [31:0] node_r; // [7:0] alert tag, [17:8] alert return path, [18] valid
    logic qnr_seen_r;
    logic [NCFG-1:0] cfg_rsp_r;
    logic [31:0] evt_r;
    aah_pkg::aah_msg_t tx_r;
    logic tx_full_r;
    logic [1:0] po_s1_r, po_s2_r, po_d_r, ae_s1_r, ae_s2_r, ae_d_r;
    // Queue
    aah_pkg::aah_alert_t q_r [DEPTH];
    logic [QW-1:0] q_wp_r, q_rp_r;
    logic [QW:0] q_cnt_r;
    aah_pkg::aah_state_t st_r;
    logic [31:0] tmr_r;
    logic [CW:0] fan_i_r;
    logic newlink_r;
    logic [1:0] nl_step_r;
    logic [7:0] out_tag_r;
    aah_pkg::aah_alert_t fan_r;
    // Decoded rx command
    wire [3:0] rx_kind = rxmsg_r[3:0];
    wire [7:0] rx_tag = rxmsg_r[11:4];
    wire [7:0] rx_code = rxmsg_r[19:12];
    wire [9:0] rx_path = rxmsg_r[29:20];
    wire is_master = ctrl_r[`AAH_CTRL_MASTER];
    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr = bus_req && wb_we_i;
    wire rxgo = wr && wb_adr_i == `AAH_REG_RXCMD && wb_dat_i[`AAH_RXC_GO];
    wire rsvd = wb_dat_i[`AAH_RXC_RSVD];
    wire unk = wb_dat_i[`AAH_RXC_UNKNOWN];
    wire match = wb_dat_i[`AAH_RXC_MATCH];
    wire q_empty = q_cnt_r == '0;
    wire q_full = q_cnt_r == (QW+1)'(DEPTH);

    function automatic aah_pkg::aah_msg_t mk_msg(input logic [3:0] k, input logic [7:0] t,
        input logic [7:0] rc, input logic [1:0] m, input logic [9:0] p);
        aah_pkg::aah_msg_t r;
        r.kind = k;
        r.tag = t;
        r.rcode = rc;
        r.mode = m;
        r.path = p;
        return r;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers and edge events
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            po_s1_r <= 2'h0;
            po_s2_r <= 2'h0;
            po_d_r <= 2'h0;
            ae_s1_r <= 2'h0;
            ae_s2_r <= 2'h0;
            ae_d_r <= 2'h0;
        end else begin
            po_s1_r <= port_oper_raw;
            po_s2_r <= po_s1_r;
            po_d_r <= po_s2_r;
            ae_s1_r <= addr_err_raw;
            ae_s2_r <= ae_s1_r;
            ae_d_r <= ae_s2_r;
        end
    end
    wire [1:0] po_rise = po_s2_r & ~po_d_r;
    wire [1:0] ae_rise = ae_s2_r & ~ae_d_r;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) port_oper_flag <= 2'h0;
        else port_oper_flag <= port_oper_flag | po_rise;
    end

    // ------------------------------------------------------------
    // Alert raise: one source per cycle, priority unknown > new link > addr err
    // ------------------------------------------------------------
    logic raise;
    aah_pkg::aah_alert_t raise_d;
    always_comb begin
        raise = 1'b0;
        raise_d = '0;
        if (rxgo && unk) begin
            raise = 1'b1;
            raise_d.code = `AAH_AC_UNKNOWN_MSG;
        end else if (|po_rise) begin
            raise = 1'b1;
            raise_d.code = `AAH_AC_PORT_OPER;
            raise_d.port = po_rise[0] ? 2'h0 : 2'h1;
        end else if (|ae_rise) begin
            raise = 1'b1;
            raise_d.code = `AAH_AC_ADDR_ERR;
            raise_d.port = ae_rise[0] ? 2'h0 : 2'h1;
        end
    end
    wire enq = raise && qnr_seen_r && !q_full;
    // start only when valid and idle queue
    wire start_now = enq && node_r[18] && q_empty && st_r == aah_pkg::AAH_IDLE;
    wire rx_reply = rxgo && !unk && rx_kind == `AAH_M_AREPLY && st_r == aah_pkg::AAH_WAIT;
    // reserved reply or matching reply ends outstanding alert
    wire reply_ok = rx_reply && (rsvd || (match && rx_tag == out_tag_r
                    && rx_code == q_r[q_rp_r].code));
    wire cfg_valid = rxgo && !unk && !rsvd && rx_kind == `AAH_M_CFGPORT;

    // ------------------------------------------------------------
    // Queue (FIFO, one outstanding)
    // ------------------------------------------------------------
    // pop only on reserved or matching reply
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            q_wp_r <= '0;
            q_rp_r <= '0;
            q_cnt_r <= '0;
        end else begin
            if (enq) q_wp_r <= QW'((q_wp_r + 1'b1) % DEPTH);
            if (reply_ok) q_rp_r <= QW'((q_rp_r + 1'b1) % DEPTH);
            q_cnt_r <= q_cnt_r + (QW+1)'(enq) - (QW+1)'(reply_ok);
        end
    end
    always_ff @(posedge mclk) begin
        if (enq) q_r[q_wp_r] <= raise_d;
    end

    // ------------------------------------------------------------
    // Node table bits
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            node_r <= 32'h0;
            qnr_seen_r <= 1'b0;
            ctrl_r <= 32'h0;
        end else begin
            if (wr && wb_adr_i == `AAH_REG_NODE) node_r[17:0] <= wb_dat_i[17:0];
            if (wr && wb_adr_i == `AAH_REG_CTRL) ctrl_r <= {30'h0, wb_dat_i[1:0]};
            if (cfg_valid) node_r[18] <= 1'b1;
            // reply counted even with reserved content
            if (rxgo && !unk && rx_kind == `AAH_M_QNODE_RPL) qnr_seen_r <= 1'b1;
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) rxmsg_r <= 32'h0;
        else if (wr && wb_adr_i == `AAH_REG_RXMSG) rxmsg_r <= wb_dat_i;
    end

    // ------------------------------------------------------------
    // Sequencer: alert send/resend, master fan-out, new-link walk
    // ------------------------------------------------------------
    wire tx_pop = wr && wb_adr_i == `AAH_REG_TXPOP;
    wire rx_resp = rxgo && !unk && !rsvd && rx_kind == `AAH_M_RESP;
    wire m_alert = rxgo && !unk && is_master && rx_kind == `AAH_M_ALERT;
    wire m_po = m_alert && rx_code == `AAH_AC_PORT_OPER;
    wire m_take = m_alert && !(m_po && newlink_r) && st_r == aah_pkg::AAH_IDLE && !tx_full_r;
    logic respond;
    aah_pkg::aah_msg_t resp_m;
    always_comb begin
        respond = 1'b0;
        resp_m = '0;
        if (rxgo && !unk && !tx_full_r) begin
            // answer on the carried return path
            case (rx_kind)
                `AAH_M_CFGPORT, `AAH_M_MALERT, `AAH_M_QUIESCE, `AAH_M_QPROT,
                `AAH_M_QPORT, `AAH_M_DREPLY: begin
                    respond = 1'b1;
                    resp_m = mk_msg(`AAH_M_RESP, rx_tag,
                        rsvd ? `AAH_RC_INVALID_FIELD : `AAH_RC_OK, 2'h0, rx_path);
                end
                `AAH_M_QNODE: begin
                    respond = 1'b1;
                    resp_m = mk_msg(`AAH_M_QNODE_RPL, rx_tag, `AAH_RC_OK, 2'h0, rx_path);
                end
                default: respond = 1'b0;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r <= aah_pkg::AAH_IDLE;
            tmr_r <= 32'h0;
            fan_i_r <= '0;
            tx_r <= '0;
            tx_full_r <= 1'b0;
            newlink_r <= 1'b0;
            nl_step_r <= 2'h0;
            out_tag_r <= 8'h0;
            fan_r <= '0;
            cfg_reset <= '0;
            evt_r <= 32'h0;
        end else begin
            cfg_reset <= '0;
            if (tx_pop) tx_full_r <= 1'b0;
            if (rxgo && rsvd && (rx_kind == `AAH_M_DREADY || rx_kind == `AAH_M_DREQ))
                evt_r[0] <= 1'b1;
            else if (wr && wb_adr_i == `AAH_REG_EVT && wb_dat_i[0]) evt_r[0] <= 1'b0;
            if (respond) begin
                tx_r <= resp_m;
                tx_full_r <= 1'b1;
            end
            case (st_r)
                aah_pkg::AAH_IDLE: begin
                    if (m_take) begin
                        tx_r <= mk_msg(`AAH_M_AREPLY, rx_tag,
                            rsvd ? `AAH_RC_INVALID_FIELD : `AAH_RC_OK, 2'h0, rx_path);
                        tx_full_r <= 1'b1;
                        fan_r <= '0;
                        fan_r.code <= rx_code;
                        fan_r.port <= rx_path[1:0];
                        fan_i_r <= '0;
                        if (m_po) begin
                            newlink_r <= 1'b1;
                            nl_step_r <= 2'h0;
                        end
                        st_r <= aah_pkg::AAH_FAN;
                    // first alert after valid, or alerts still queued while idle and not master
                    end else if (start_now || (node_r[18] && !q_empty && !is_master)) begin
                        st_r <= aah_pkg::AAH_SEND;
                    end
                end
                aah_pkg::AAH_SEND: begin
                    if (q_empty) st_r <= aah_pkg::AAH_IDLE;
                    else if (!tx_full_r && !respond) begin
                        // tag and path from node table
                        tx_r <= mk_msg(`AAH_M_ALERT, node_r[7:0], q_r[q_rp_r].code,
                            q_r[q_rp_r].port, node_r[17:8]);
                        out_tag_r <= node_r[7:0];
                        tx_full_r <= 1'b1;
                        tmr_r <= 32'h0;
                        st_r <= aah_pkg::AAH_WAIT;
                    end
                end
                aah_pkg::AAH_WAIT: begin
                    tmr_r <= tmr_r + 32'h1;
                    if (reply_ok) st_r <= aah_pkg::AAH_SEND;
                    else if (tmr_r >= 32'(RESEND_CYC - 1)) st_r <= aah_pkg::AAH_SEND;
                end
                aah_pkg::AAH_FAN: begin
                    if (!tx_full_r && !respond) begin
                        // one master alert per configuring node
                        tx_r <= mk_msg(`AAH_M_MALERT, 8'(fan_i_r), fan_r.code, 2'h0,
                            10'(fan_i_r));
                        tx_full_r <= 1'b1;
                        fan_i_r <= fan_i_r + 1'b1;
                        if (fan_i_r == (CW+1)'(NCFG - 1)) begin
                            tmr_r <= 32'h0;
                            st_r <= aah_pkg::AAH_FWAIT;
                        end
                    end
                end
                aah_pkg::AAH_FWAIT: begin
                    tmr_r <= tmr_r + 32'h1;
                    if (&cfg_rsp_r) st_r <= newlink_r ? aah_pkg::AAH_NEWL : aah_pkg::AAH_IDLE;
                    // reset silent nodes after 1 s
                    else if (tmr_r >= 32'(MRSP_CYC - 1)) begin
                        cfg_reset <= ~cfg_rsp_r;
                        st_r <= newlink_r ? aah_pkg::AAH_NEWL : aah_pkg::AAH_IDLE;
                    end
                end
                aah_pkg::AAH_NEWL: begin
                    if (!tx_full_r && !respond && nl_step_r != 2'h3) begin
                        case (nl_step_r)
                            2'h0: tx_r <= mk_msg(`AAH_M_QNODE, 8'h0, 8'h0, 2'h0, 10'h0);
                            2'h1: tx_r <= mk_msg(`AAH_M_CFGPORT, 8'h0, 8'h0,
                                `AAH_MODE_NO_CHANGE, 10'h0);
                            default: tx_r <= mk_msg(`AAH_M_CFGPORT, 8'h0, 8'h0,
                                `AAH_MODE_SET_NORMAL, 10'h0);
                        endcase
                        tx_full_r <= 1'b1;
                        nl_step_r <= nl_step_r + 2'h1;
                    end else if (nl_step_r == 2'h3 && !tx_full_r && !respond) begin
                        // both-normal, or all-normal in a loop
                        fan_r.code <= ctrl_r[`AAH_CTRL_LOOP] ? `AAH_AC_ALL_NORMAL
                            : `AAH_AC_BOTH_NORMAL;
                        fan_i_r <= '0;
                        newlink_r <= 1'b0;
                        st_r <= aah_pkg::AAH_FAN;
                    end
                end
                default: st_r <= aah_pkg::AAH_IDLE;
            endcase
        end
    end

    // Response collection from configuring nodes; set wins over clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) cfg_rsp_r <= '0;
        else if (rx_resp && rx_tag < 8'(NCFG)) cfg_rsp_r[CW'(rx_tag)] <= 1'b1;
        else if (st_r == aah_pkg::AAH_FAN) cfg_rsp_r <= '0;
    end

    // ------------------------------------------------------------
    // Wishbone slave: one registered ack a cycle after the request, unmapped reads zero
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= 32'h0;
            if (bus_req && !wb_we_i) begin
                if (wb_adr_i == `AAH_REG_CTRL) wb_dat_o <= ctrl_r;
                else if (wb_adr_i == `AAH_REG_STAT) wb_dat_o <= 32'({q_cnt_r, tx_full_r,
                    qnr_seen_r, node_r[18], newlink_r, st_r});
                else if (wb_adr_i == `AAH_REG_RXMSG) wb_dat_o <= rxmsg_r;
                else if (wb_adr_i == `AAH_REG_TXMSG) wb_dat_o <= tx_r;
                else if (wb_adr_i == `AAH_REG_ALERT) wb_dat_o <= q_r[q_rp_r];
                else if (wb_adr_i == `AAH_REG_NODE) wb_dat_o <= node_r;
                else if (wb_adr_i == `AAH_REG_CFGRSP) wb_dat_o <= 32'(cfg_rsp_r);
                else if (wb_adr_i == `AAH_REG_EVT) wb_dat_o <= evt_r;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_drop_noqnr: assert property (@(posedge mclk) disable iff (rst)
        raise && !qnr_seen_r |=> q_cnt_r == $past(q_cnt_r) - (QW+1)'($past(reply_ok)))
        else $error("alert queued before query-node reply");
    chk_empty_exit: assert property (@(posedge mclk) disable iff (rst)
        st_r == aah_pkg::AAH_SEND && q_empty |=> st_r == aah_pkg::AAH_IDLE && !$rose(tx_full_r))
        else $error("empty de-queue sent");
    chk_resend_time: assert property (@(posedge mclk) disable iff (rst)
        st_r == aah_pkg::AAH_WAIT |-> tmr_r < 32'(RESEND_CYC))
        else $error("resend late");
    chk_start_now: assert property (@(posedge mclk) disable iff (rst)
        start_now && !m_take |=> st_r == aah_pkg::AAH_SEND)
        else $error("de-queue not started");
    chk_fifo_pop: assert property (@(posedge mclk) disable iff (rst)
        !reply_ok |=> q_rp_r == $past(q_rp_r))
        else $error("queue advanced without reply");
    chk_inval_resp: assert property (@(posedge mclk) disable iff (rst)
        respond && rsvd && rx_kind == `AAH_M_QUIESCE |=> tx_r.rcode == `AAH_RC_INVALID_FIELD)
        else $error("invalid field not returned");
    chk_mrsp_time: assert property (@(posedge mclk) disable iff (rst)
        st_r == aah_pkg::AAH_FWAIT |-> tmr_r < 32'(MRSP_CYC))
        else $error("master alert wait overran");
    chk_oper_flag: assert property (@(posedge mclk) disable iff (rst)
        |po_rise |=> (port_oper_flag & $past(po_rise)) == $past(po_rise))
        else $error("operational flag not set");
endmodule
`default_nettype wire

// *** include/aah_consts.svh ***
`ifndef AAH_CONSTS_SVH
`define AAH_CONSTS_SVH
// Register byte offsets
`define AAH_REG_CTRL 8'h00
`define AAH_REG_STAT 8'h04
`define AAH_REG_RXMSG 8'h08
`define AAH_REG_RXCMD 8'h0C
`define AAH_REG_TXMSG 8'h10
`define AAH_REG_TXPOP 8'h14
`define AAH_REG_ALERT 8'h18
`define AAH_REG_NODE 8'h1C
`define AAH_REG_CFGRSP 8'h20
`define AAH_REG_EVT 8'h24
// Control bits
`define AAH_CTRL_MASTER 0
`define AAH_CTRL_LOOP 1
// Rx command bits
`define AAH_RXC_GO 0
`define AAH_RXC_RSVD 1
`define AAH_RXC_UNKNOWN 2
`define AAH_RXC_MATCH 3
// Message codes (4-bit)
`define AAH_M_QNODE 4'h0
`define AAH_M_QNODE_RPL 4'h1
`define AAH_M_CFGPORT 4'h2
`define AAH_M_RESP 4'h3
`define AAH_M_ALERT 4'h4
`define AAH_M_MALERT 4'h5
`define AAH_M_QUIESCE 4'h6
`define AAH_M_AREPLY 4'h7
`define AAH_M_QPROT 4'h8
`define AAH_M_QPROT_RPL 4'h9
`define AAH_M_QPORT 4'hA
`define AAH_M_QPORT_RPL 4'hB
`define AAH_M_DREADY 4'hC
`define AAH_M_DREPLY 4'hD
`define AAH_M_DREQ 4'hE
// Return and alert codes
`define AAH_RC_OK 8'h00
`define AAH_RC_INVALID_FIELD 8'h01
`define AAH_AC_UNKNOWN_MSG 8'h10
`define AAH_AC_ADDR_ERR 8'h11
`define AAH_AC_PORT_OPER 8'h12
`define AAH_AC_BOTH_NORMAL 8'h20
`define AAH_AC_ALL_NORMAL 8'h21
// Config-port modes
`define AAH_MODE_NO_CHANGE 2'h0
`define AAH_MODE_SET_NORMAL 2'h1
// Timing
`define AAH_CLK_HZ 25000000
`define AAH_RESEND_MS 500
`define AAH_MRSP_MS 1000
`define AAH_RESEND_CYC ((`AAH_CLK_HZ / 1000) * `AAH_RESEND_MS)
`define AAH_MRSP_CYC ((`AAH_CLK_HZ / 1000) * `AAH_MRSP_MS)
`endif

// *** include/aah_pkg.sv ***
package aah_pkg;
    // Alert parameters kept in the queue
    typedef struct packed {
        logic [7:0] code;
        logic [1:0] port;
        logic [7:0] ctrl;
        logic [7:0] chan;
        logic [5:0] data;
    } aah_alert_t;
    // Outgoing message word
    typedef struct packed {
        logic [3:0] kind;
        logic [7:0] tag;
        logic [7:0] rcode;
        logic [1:0] mode;
        logic [9:0] path;
    } aah_msg_t;
    typedef enum logic [5:0] {
        AAH_IDLE = 6'b000001,
        AAH_SEND = 6'b000010,
        AAH_WAIT = 6'b000100,
        AAH_FAN = 6'b001000,
        AAH_FWAIT = 6'b010000,
        AAH_NEWL = 6'b100000
    } aah_state_t;
endpackage

// *** verif/aah_link_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module aah_link_model (
    input wire logic mclk, // Clock
    input wire logic rst, // Reset
    input wire logic [1:0] link_req, // Connect a link
    input wire logic [1:0] err_req, // Misrouted frame seen
    output logic [1:0] port_oper_raw, // Link pins
    output logic [1:0] addr_err_raw // Error pins
);
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            port_oper_raw <= 2'h0;
            addr_err_raw <= 2'h0;
        end else begin
            port_oper_raw <= port_oper_raw | link_req;
            addr_err_raw <= err_req;
        end
    end
endmodule
`default_nettype wire

// *** verif/async_alert_handler_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "aah_consts.svh"
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin err_total++; \
    $display("unexpected %s exp %0h got %0h", n, e, a); end end
module async_alert_handler_tb_top;
    logic mclk = 0, rst = 1, we = 0, cyc = 0, stb = 0, ack, seen_rst = 0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dw = 32'h0, dr, rd;
    logic [1:0] lreq = 2'h0, ereq = 2'h0, raw_o, raw_e, oflag;
    logic [3:0] creset;
    logic [3:0] req_k[6] = '{`AAH_M_CFGPORT, `AAH_M_MALERT, `AAH_M_QUIESCE,
        `AAH_M_QPROT, `AAH_M_QPORT, `AAH_M_DREPLY};
    logic [3:0] drop_k[5] = '{`AAH_M_RESP, `AAH_M_QPROT_RPL, `AAH_M_QPORT_RPL,
        `AAH_M_DREADY, `AAH_M_DREQ};
    int err_total = 0, checks_done = 0, cyc_n = 0, nm = 0, nq = 0, nb = 0;
    aah_pkg::aah_msg_t m;
    always #20 mclk = ~mclk;
    aah_link_model lm (.mclk(mclk), .rst(rst), .link_req(lreq), .err_req(ereq),
        .port_oper_raw(raw_o), .addr_err_raw(raw_e));
    aah_core #(.RESEND_CYC(50), .MRSP_CYC(80)) uut (.mclk(mclk), .rst(rst),
        .wb_adr_i(adr), .wb_dat_i(dw), .wb_dat_o(dr), .wb_we_i(we), .wb_sel_i(4'hF),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .port_oper_raw(raw_o),
        .addr_err_raw(raw_e), .port_oper_flag(oflag), .cfg_reset(creset));
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dw <= d;
        do @(posedge mclk); while (ack !== 1'b1);
        rd = dr;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic send(input logic [3:0] k, input logic [7:0] t, input logic [7:0] c,
        input logic [3:0] cmd);
        bus(1, `AAH_REG_RXMSG, {2'h0, 10'h2A5, c, t, k});
        bus(1, `AAH_REG_RXCMD, {28'h0, cmd});
        repeat (4) @(posedge mclk);
        bus(0, `AAH_REG_STAT, 0);
    endtask
    task automatic pop();
        bus(0, `AAH_REG_TXMSG, 0);
        m = rd;
        bus(1, `AAH_REG_TXPOP, 0);
    endtask
    task automatic pulse_err();
        ereq <= 2'h2;
        repeat (6) @(posedge mclk);
        ereq <= 2'h0;
        repeat (6) @(posedge mclk);
        bus(0, `AAH_REG_STAT, 0);
    endtask
    task automatic wait_tx();
        for (int i = 0; i < 40 && rd[9] !== 1'b1; i++) bus(0, `AAH_REG_STAT, 0);
    endtask
    // Pop what the block sends over n polls and count master alerts, query-node and both-normal alerts
    task automatic drain(input int n);
        for (int i = 0; i < n; i++) begin
            bus(0, `AAH_REG_STAT, 0);
            if (rd[9] === 1'b1) begin
                pop();
                if (m.kind == `AAH_M_MALERT) nm++;
                if (m.kind == `AAH_M_QNODE) nq++;
                if (m.kind == `AAH_M_MALERT && m.rcode == `AAH_AC_BOTH_NORMAL) nb++;
            end
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ----------------------------------------
    // Watchdog and reset-pulse capture
    // ----------------------------------------
    always @(posedge mclk) begin
        cyc_n++;
        if (creset !== 4'h0 && !rst) seen_rst = 1'b1;
        if (cyc_n == 20000) begin
            err_total++;
            finish_test();
        end
    end
    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        bus(0, 8'h3C, 0);
        `CHK("unmapped", 32'h0, rd)
        lreq <= 2'h1;
        pulse_err();
        `CHK("oper flag", 2'h1, oflag)
        `CHK("early queue", 3'h0, rd[12:10])
        $display("test early alerts done");
        foreach (req_k[i]) begin
            send(req_k[i], 8'h5A, 8'h00, 4'h3);
            pop();
            `CHK("rsvd kind", `AAH_M_RESP, m.kind)
            `CHK("rsvd rcode", `AAH_RC_INVALID_FIELD, m.rcode)
            `CHK("rsvd path", 10'h2A5, m.path)
        end
        foreach (drop_k[i]) begin
            send(drop_k[i], 8'h5A, 8'h00, 4'h3);
            `CHK("discard", 1'b0, rd[9])
        end
        bus(0, `AAH_REG_EVT, 0);
        `CHK("io cancel", 1'b1, rd[0])
        send(`AAH_M_QNODE, 8'h11, 8'h00, 4'h3);
        pop();
        `CHK("qnode reply", `AAH_M_QNODE_RPL, m.kind)
        send(`AAH_M_QNODE_RPL, 8'h11, 8'h00, 4'h3);
        `CHK("qnr silent", 1'b0, rd[9])
        send(`AAH_M_QNODE_RPL, 8'h11, 8'h00, 4'h1);
        $display("test reserved content done");
        send(`AAH_M_CFGPORT, 8'h33, 8'h00, 4'h1);
        pop();
        `CHK("cfg rcode", `AAH_RC_OK, m.rcode)
        bus(0, `AAH_REG_NODE, 0);
        `CHK("aa valid", 1'b1, rd[18])
        pulse_err();
        wait_tx();
        pop();
        `CHK("alert kind", `AAH_M_ALERT, m.kind)
        `CHK("alert code", `AAH_AC_ADDR_ERR, m.rcode)
        bus(0, `AAH_REG_ALERT, 0);
        `CHK("queue head", `AAH_AC_ADDR_ERR, rd[31:24])
        send(4'hF, 8'h00, 8'h00, 4'h5);
        `CHK("held back", 1'b0, rd[9])
        wait_tx();
        pop();
        `CHK("resend code", `AAH_AC_ADDR_ERR, m.rcode)
        send(`AAH_M_AREPLY, m.tag, `AAH_AC_ADDR_ERR, 4'h9);
        wait_tx();
        pop();
        `CHK("next alert", `AAH_AC_UNKNOWN_MSG, m.rcode)
        send(`AAH_M_AREPLY, m.tag, `AAH_AC_UNKNOWN_MSG, 4'hB);
        repeat (70) @(posedge mclk);
        bus(0, `AAH_REG_STAT, 0);
        `CHK("no resend", 1'b0, rd[9])
        $display("test alert queue done");
        bus(1, `AAH_REG_CTRL, 32'h1);
        send(`AAH_M_ALERT, 8'h44, `AAH_AC_ADDR_ERR, 4'h3);
        pop();
        `CHK("m rsvd", `AAH_RC_INVALID_FIELD, m.rcode)
        drain(60);
        `CHK("fan out", 4, nm)
        `CHK("silent reset", 1'b1, seen_rst)
        send(`AAH_M_ALERT, 8'h45, `AAH_AC_ADDR_ERR, 4'h1);
        pop();
        `CHK("m tag", 8'h45, m.tag)
        drain(60);
        send(`AAH_M_ALERT, 8'h46, `AAH_AC_PORT_OPER, 4'h1);
        pop();
        drain(150);
        `CHK("walk query", 1, nq)
        `CHK("both normal", 4, nb)
        $display("test master done");
        finish_test();
    end
endmodule
`default_nettype wire
